// ===== gpwk_pkg.sv
package gpwk_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] P5_DATA_IDX = 16'hFFD8;
  localparam logic [15:0] P5_DIR_IDX = 16'hFFE8;
  localparam logic [15:0] P5_PULL_IDX = 16'hFF9E;
  localparam logic [15:0] P5_FUNC_IDX = 16'hFF9B;
  localparam logic [15:0] P6_DATA_IDX = 16'hFFD9;
  localparam logic [15:0] P6_DIR_IDX = 16'hFFE9;
  localparam logic [15:0] P6_PULL_IDX = 16'hFF9F;

  localparam logic [31:0] P5_DATA_ADDR = {14'h0000, P5_DATA_IDX, 2'b00};
  localparam logic [31:0] P5_DIR_ADDR = {14'h0000, P5_DIR_IDX, 2'b00};
  localparam logic [31:0] P5_PULL_ADDR = {14'h0000, P5_PULL_IDX, 2'b00};
  localparam logic [31:0] P5_FUNC_ADDR = {14'h0000, P5_FUNC_IDX, 2'b00};
  localparam logic [31:0] P6_DATA_ADDR = {14'h0000, P6_DATA_IDX, 2'b00};
  localparam logic [31:0] P6_DIR_ADDR = {14'h0000, P6_DIR_IDX, 2'b00};
  localparam logic [31:0] P6_PULL_ADDR = {14'h0000, P6_PULL_IDX, 2'b00};

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] WO_READ = 8'hFF;
  localparam int REG_WIDTH = 8;

  typedef enum logic [2:0]
  {
    GPWK_ACTIVE = 3'b000,
    GPWK_SUBACTIVE = 3'b001,
    GPWK_SLEEP = 3'b010,
    GPWK_SUBSLEEP = 3'b011,
    GPWK_STANDBY = 3'b100,
    GPWK_WATCH = 3'b101
  } gpwk_mode_t;

endpackage : gpwk_pkg

// ===== gpwk_pin.sv
`timescale 1ns/1ns
module gpwk_pin
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pad_in,
  input wire logic dir,
  input wire logic data,
  input wire logic pull_ctl,
  input wire logic wake_sel,
  input wire logic functional,
  input wire logic hiz,
  output logic level,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pullup_en,
  output logic wake_req_n
);

  logic sync1;
  wire drive = dir & ~wake_sel;
  wire pull_on = ~dir & pull_ctl;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 1'b0;
      level <= 1'b0;
    end
    else if (ce)
    begin
      sync1 <= pad_in;
      level <= sync1;
    end
  end

  // pad controls follow the registers in the functional modes; standby floats pins with pull-ups still following; others hold
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
      pullup_en <= 1'b0;
    end
    else if (ce)
    begin
      if (functional)
      begin
        pad_out <= data & drive;
        pad_oe_n <= ~drive;
        pullup_en <= pull_on;
      end
      else if (hiz)
      begin
        pad_oe_n <= 1'b1;
        pullup_en <= pull_on;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_req_n <= 1'b1;
    else if (ce)
      wake_req_n <= wake_sel ? level : 1'b1;
  end

endmodule : gpwk_pin

// ===== gpwk_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module gpwk_top
#(
  parameter int PORT_WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] pwr_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PORT_WIDTH-1:0] first_port_pin_in,
  output logic [PORT_WIDTH-1:0] first_port_pin_out,
  output logic [PORT_WIDTH-1:0] first_port_pin_oe_n,
  output logic [PORT_WIDTH-1:0] first_port_pullup_en,
  output logic [PORT_WIDTH-1:0] wakeup_req_n,
  input wire logic [PORT_WIDTH-1:0] second_port_pin_in,
  output logic [PORT_WIDTH-1:0] second_port_pin_out,
  output logic [PORT_WIDTH-1:0] second_port_pin_oe_n,
  output logic [PORT_WIDTH-1:0] second_port_pullup_en
);

  if (PORT_WIDTH < 1 || PORT_WIDTH > gpwk_pkg::REG_WIDTH)
  begin : g_width_check
    $error("PORT_WIDTH must lie between 1 and 8");
  end

  localparam int PAD = 32 - PORT_WIDTH;

  logic [PORT_WIDTH-1:0] port5_data_latch;
  logic [PORT_WIDTH-1:0] port5_direction;
  logic [PORT_WIDTH-1:0] port5_pullup_control;
  logic [PORT_WIDTH-1:0] port5_pin_function_select;
  logic [PORT_WIDTH-1:0] port6_data_latch;
  logic [PORT_WIDTH-1:0] port6_direction;
  logic [PORT_WIDTH-1:0] port6_pullup_control;
  logic [PORT_WIDTH-1:0] first_level;
  logic [PORT_WIDTH-1:0] second_level;

  // power mode decode
  wire functional = (pwr_mode == gpwk_pkg::GPWK_ACTIVE)
                  || (pwr_mode == gpwk_pkg::GPWK_SUBACTIVE);
  wire hiz = (pwr_mode == gpwk_pkg::GPWK_STANDBY);

  // bus decode
  wire setup = psel & ~penable;
  wire hit_p5_data = (paddr == gpwk_pkg::P5_DATA_ADDR);
  wire hit_p5_dir = (paddr == gpwk_pkg::P5_DIR_ADDR);
  wire hit_p5_pull = (paddr == gpwk_pkg::P5_PULL_ADDR);
  wire hit_p5_func = (paddr == gpwk_pkg::P5_FUNC_ADDR);
  wire hit_p6_data = (paddr == gpwk_pkg::P6_DATA_ADDR);
  wire hit_p6_dir = (paddr == gpwk_pkg::P6_DIR_ADDR);
  wire hit_p6_pull = (paddr == gpwk_pkg::P6_PULL_ADDR);
  wire hit_any = hit_p5_data | hit_p5_dir | hit_p5_pull | hit_p5_func
               | hit_p6_data | hit_p6_dir | hit_p6_pull;

  // writes land only at the completing access edge, low byte lane only
  wire wr = psel & penable & pready & pwrite & pstrb[0];
  wire [PORT_WIDTH-1:0] wbyte = pwdata[PORT_WIDTH-1:0];

  // driving pins (direction set, port 5 wakeup select clear) read back their latch, others the synced pin
  wire [PORT_WIDTH-1:0] p5_out_dir = port5_direction & ~port5_pin_function_select;
  wire [PORT_WIDTH-1:0] p5_read = (port5_data_latch & p5_out_dir)
                                | (first_level & ~p5_out_dir);
  wire [PORT_WIDTH-1:0] p6_read = (port6_data_latch & port6_direction)
                                | (second_level & ~port6_direction);
  wire [PORT_WIDTH-1:0] wo_ones = gpwk_pkg::WO_READ[PORT_WIDTH-1:0];

  logic [PORT_WIDTH-1:0] read_byte;
  always_comb
  begin
    read_byte = '0;
    if (hit_p5_data)
      read_byte = p5_read;
    if (hit_p5_dir)
      read_byte = wo_ones;
    if (hit_p5_pull)
      read_byte = port5_pullup_control;
    if (hit_p5_func)
      read_byte = port5_pin_function_select;
    if (hit_p6_data)
      read_byte = p6_read;
    if (hit_p6_dir)
      read_byte = wo_ones;
    if (hit_p6_pull)
      read_byte = port6_pullup_control;
  end

  // answer one cycle after setup: access phase sees pready high at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (ce)
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= ~hit_any;
        prdata <= pwrite ? 32'h00000000 : {{PAD{1'b0}}, read_byte};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port5_data_latch <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
      port5_direction <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
      port5_pullup_control <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
      port5_pin_function_select <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
    end
    else if (ce && wr)
    begin
      if (hit_p5_data)
        port5_data_latch <= wbyte;
      if (hit_p5_dir)
        port5_direction <= wbyte;
      if (hit_p5_pull)
        port5_pullup_control <= wbyte;
      if (hit_p5_func)
        port5_pin_function_select <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port6_data_latch <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
      port6_direction <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
      port6_pullup_control <= gpwk_pkg::REG_RESET[PORT_WIDTH-1:0];
    end
    else if (ce && wr)
    begin
      if (hit_p6_data)
        port6_data_latch <= wbyte;
      if (hit_p6_dir)
        port6_direction <= wbyte;
      if (hit_p6_pull)
        port6_pullup_control <= wbyte;
    end
  end

  for (genvar i = 0; i < PORT_WIDTH; i++)
  begin : g_pins
    gpwk_pin u_first
    (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pad_in(first_port_pin_in[i]),
      .dir(port5_direction[i]),
      .data(port5_data_latch[i]),
      .pull_ctl(port5_pullup_control[i]),
      .wake_sel(port5_pin_function_select[i]),
      .functional(functional),
      .hiz(hiz),
      .level(first_level[i]),
      .pad_out(first_port_pin_out[i]),
      .pad_oe_n(first_port_pin_oe_n[i]),
      .pullup_en(first_port_pullup_en[i]),
      .wake_req_n(wakeup_req_n[i])
    );

    gpwk_pin u_second
    (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pad_in(second_port_pin_in[i]),
      .dir(port6_direction[i]),
      .data(port6_data_latch[i]),
      .pull_ctl(port6_pullup_control[i]),
      .wake_sel(1'b0),
      .functional(functional),
      .hiz(hiz),
      .level(second_level[i]),
      .pad_out(second_port_pin_out[i]),
      .pad_oe_n(second_port_pin_oe_n[i]),
      .pullup_en(second_port_pullup_en[i]),
      .wake_req_n()
    );
  end

endmodule : gpwk_top

// ===== gpwk_top_props.sv
`timescale 1ns/1ns
module gpwk_top_props
#(
  parameter int PORT_WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] pwr_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PORT_WIDTH-1:0] first_port_pin_oe_n,
  input wire logic [PORT_WIDTH-1:0] first_port_pullup_en,
  input wire logic [PORT_WIDTH-1:0] second_port_pin_out,
  input wire logic [PORT_WIDTH-1:0] second_port_pin_oe_n,
  input wire logic [PORT_WIDTH-1:0] second_port_pullup_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("pready high twice");
  a_setup_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  a_dir_ones: assert property (pready && !pwrite &&
    (paddr == gpwk_pkg::P5_DIR_ADDR || paddr == gpwk_pkg::P6_DIR_ADDR) |-> prdata == 32'h000000FF)
    else $error("direction read not ones");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_out_pull_off: assert property ((second_port_pullup_en & ~second_port_pin_oe_n) == 0)
    else $error("second port pull-up on output");
  a_drive_pull_off: assert property ((first_port_pullup_en & ~first_port_pin_oe_n) == 0)
    else $error("first port pull-up on output");
  a_standby_hiz: assert property (pwr_mode == 3'b100 && ce |=>
    &first_port_pin_oe_n && &second_port_pin_oe_n)
    else $error("pin driven in standby");
  a_sleep_hold: assert property (pwr_mode inside {3'b010, 3'b011, 3'b101}
    && $past(pwr_mode) == pwr_mode
    |-> $stable(second_port_pin_out) && $stable(second_port_pin_oe_n))
    else $error("pin moved in sleep");
  c_err: cover property (pready && pslverr);
  c_standby: cover property (pwr_mode == 3'b100);
  c_sleep: cover property (pwr_mode == 3'b010);
endmodule : gpwk_top_props

bind gpwk_top gpwk_top_props #(.PORT_WIDTH(PORT_WIDTH)) u_gpwk_top_props (.clk, .rst_n, .ce,
  .pwr_mode, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .first_port_pin_oe_n, .first_port_pullup_en, .second_port_pin_out,
  .second_port_pin_oe_n, .second_port_pullup_en);

// ===== gpwk_board.sv
`timescale 1ns/1ns
module gpwk_board
(
  input wire logic clk,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] out,
  input wire logic [7:0] pu,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext,
  output logic [7:0] lvl
);
  logic [7:0] flt = 8'h5A;
  // a released, unpulled pin wanders every cycle
  always @(posedge clk)
    flt <= ~flt;
  assign lvl = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pu | flt));
endmodule : gpwk_board

// ===== gpio_port5_wakeup_port6_bench.sv
`timescale 1ns/1ns
module gpio_port5_wakeup_port6_bench;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [2:0] mode;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [7:0] i5, o5, e5, u5, w5, i6, o6, e6, u6;
  logic [7:0] d5, s5, f5, p5, m5, d6, s6, p6, x5, x6, xen, c;
  int n_mismatch, checks_done, cyc;
  gpwk_top u_gpwk_top (.clk(clk), .rst_n(rst_n), .ce(ce), .pwr_mode(mode), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_port_pin_in(i5),
    .first_port_pin_out(o5), .first_port_pin_oe_n(e5), .first_port_pullup_en(u5),
    .wakeup_req_n(w5), .second_port_pin_in(i6), .second_port_pin_out(o6),
    .second_port_pin_oe_n(e6), .second_port_pullup_en(u6));
  gpwk_board u_gpwk_board (.clk(clk), .oe_n(e5), .out(o5), .pu(u5), .ext_en(xen), .ext(x5),
    .lvl(i5));
  gpwk_board u_gpwk_board_b (.clk(clk), .oe_n(e6), .out(o6), .pu(u6), .ext_en(xen), .ext(x6),
    .lvl(i6));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd[7:0], e);
  endtask : rc
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    seed = 32'd1051;
    {rst_n, psel, penable, pwrite, paddr, pwdata, mode} = '0;
    ce = 1'b1;
    {n_mismatch, checks_done} = '0;
    xen = 8'hFF;
    x5 = 8'hA5;
    x6 = 8'h3C;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(e6, 8'hFF);
    chk(e5, 8'hFF);
    chk(u5, 8'h00);
    rc(gpwk_pkg::P5_FUNC_ADDR, 8'h00);
    rc(gpwk_pkg::P6_PULL_ADDR, 8'h00);
    rc(gpwk_pkg::P5_DIR_ADDR, 8'hFF);
    rc(gpwk_pkg::P6_DIR_ADDR, 8'hFF);
    rc(gpwk_pkg::P6_DATA_ADDR, x6);
    apb(1'b0, 32'h00000040, 8'h00);
    chk({7'h00, er}, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 20; i++)
    begin
      {d5, s5, f5, p5, d6, s6, p6} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      if (i == 0)
        {d5, f5} = 16'hFFFF;
      // odd rounds run in subactive, which must behave like active
      mode <= (i % 2 == 1) ? 3'b001 : 3'b000;
      m5 = d5 & ~f5;
      x5 <= rnd();
      x6 <= rnd();
      apb(1'b1, gpwk_pkg::P5_FUNC_ADDR, f5);
      apb(1'b1, gpwk_pkg::P5_DIR_ADDR, d5);
      apb(1'b1, gpwk_pkg::P5_DATA_ADDR, s5);
      apb(1'b1, gpwk_pkg::P5_PULL_ADDR, p5);
      apb(1'b1, gpwk_pkg::P6_DIR_ADDR, d6);
      apb(1'b1, gpwk_pkg::P6_DATA_ADDR, s6);
      apb(1'b1, gpwk_pkg::P6_PULL_ADDR, p6);
      repeat (4) @(posedge clk);
      chk(e5, ~m5);
      chk(o5 & m5, s5 & m5);
      chk(u5, p5 & ~d5);
      chk(w5, ~f5 | x5);
      chk(e6, ~d6);
      chk(o6 & d6, s6 & d6);
      chk(u6, p6 & ~d6);
      rc(gpwk_pkg::P5_DATA_ADDR, (m5 & s5) | (~m5 & x5));
      rc(gpwk_pkg::P6_DATA_ADDR, (d6 & s6) | (~d6 & x6));
      rc(gpwk_pkg::P5_FUNC_ADDR, f5);
      rc(gpwk_pkg::P6_PULL_ADDR, p6);
    end
    // clock enable low freezes the synchronisers and the wakeup request
    c = w5;
    ce <= 1'b0;
    x5 <= ~x5;
    repeat (4) @(posedge clk);
    chk(w5, c);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk(w5, ~f5 | x5);
    $display("random test done");
    // all second port pins drive, so every retained bit is visible
    d6 = 8'hFF;
    apb(1'b1, gpwk_pkg::P6_DIR_ADDR, d6);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++)
    begin
      mode <= (k == 0) ? 3'b010 : (k == 1) ? 3'b011 : 3'b101;
      @(posedge clk);
      c = o6;
      s6 = ~s6;
      apb(1'b1, gpwk_pkg::P6_DATA_ADDR, s6);
      repeat (4) @(posedge clk);
      chk(o6, c);
      mode <= 3'b000;
      repeat (4) @(posedge clk);
      chk(o6 & d6, s6 & d6);
    end
    xen <= 8'h00;
    mode <= 3'b100;
    repeat (4) @(posedge clk);
    chk(e5 & e6, 8'hFF);
    // pull-ups keep following their registers while in standby
    apb(1'b1, gpwk_pkg::P6_DIR_ADDR, 8'h00);
    apb(1'b1, gpwk_pkg::P6_PULL_ADDR, 8'hF0);
    repeat (4) @(posedge clk);
    chk(u6, 8'hF0);
    chk(i6 | ~u6, 8'hFF);
    mode <= 3'b000;
    xen <= 8'hFF;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(e6, 8'hFF);
    apb(1'b1, gpwk_pkg::P6_DIR_ADDR, 8'hFF);
    repeat (3) @(posedge clk);
    rc(gpwk_pkg::P6_DATA_ADDR, 8'h00);
    $display("power test done");
    results();
  end
endmodule : gpio_port5_wakeup_port6_bench
